// ===== hw/arac_consts.svh
`ifndef ARAC_CONSTS_SVH
`define ARAC_CONSTS_SVH

// Register offsets
`define ARAC_OFF_CLKDIV 8'h00
`define ARAC_OFF_REFSEL 8'h01
`define ARAC_OFF_PRE_LO 8'h02
`define ARAC_OFF_PRE_HI 8'h03
`define ARAC_OFF_CTRL2 8'h04
`define ARAC_OFF_ACQ 8'h05
`define ARAC_OFF_RPT 8'h06
`define ARAC_OFF_TRIGSEL 8'h07
`define ARAC_OFF_START 8'h08
`define ARAC_OFF_STATUS 8'h09
`define ARAC_OFF_SUM_LO 8'h0a
`define ARAC_OFF_SUM_HI 8'h0b
`define ARAC_OFF_SUM_UP 8'h0c
`define ARAC_OFF_FLT_LO 8'h0d
`define ARAC_OFF_FLT_HI 8'h0e
`define ARAC_OFF_CNT 8'h0f
`define ARAC_OFF_THR_LO 8'h10
`define ARAC_OFF_THR_HI 8'h11

// Field positions
`define ARAC_CTRL2_CLR_BIT 3
`define ARAC_REF_NEG_BIT 4
`define ARAC_START_GO_BIT 0
`define ARAC_START_RC_BIT 1
`define ARAC_TRIG_CMP_BIT 0
`define ARAC_STAT_OVF_BIT 0
`define ARAC_STAT_THR_BIT 1

// Computation mode codes
`define ARAC_MD_BASIC 3'h0
`define ARAC_MD_ACCUM 3'h1
`define ARAC_MD_AVG 3'h2
`define ARAC_MD_BURST 3'h3
`define ARAC_MD_LPF 3'h4

// Reset values and timing
`define ARAC_RST_BYTE 8'h00
`define ARAC_THR_RST 16'hffff
`define ARAC_RC_CLEAR_CYC 3'h5
`define ARAC_SAMP_DEFAULT 9'h100
`define ARAC_CNT_MAX 8'hff

`endif

// ===== hw/arac_pkg.sv
package arac_pkg;

	// Result handed over by the converter core
	typedef struct packed {
		logic valid;
		logic [11:0] data;
	} arac_result_t;

	// Reference switch settings towards the analog core
	typedef struct packed {
		logic [1:0] pos_ref_select;
		logic negative_ref_select;
	} arac_ref_t;

	typedef enum logic {
		ARAC_CLR_IDLE,
		ARAC_CLR_WAIT
	} arac_clr_state_t;

endpackage

// ===== hw/arac_top.sv
`include "arac_consts.svh"

module arac_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire arac_pkg::arac_result_t conv_result,
	input wire logic cmp_out,
	input wire logic internal_rc_oscillator,
	output logic conv_start,
	output logic conv_clk,
	output arac_pkg::arac_ref_t ref_cfg,
	output logic [12:0] precharge_cycles,
	output logic precharge_en,
	output logic [8:0] sample_cycles,
	output logic [15:0] filtered_result,
	output logic threshold_event_flag
);

	// Mode decode shared by accumulation and comparison paths
	function automatic logic is_acc_mode(input logic [2:0] md);
		is_acc_mode = (md == `ARAC_MD_ACCUM) || (md == `ARAC_MD_AVG) ||
			(md == `ARAC_MD_BURST) || (md == `ARAC_MD_LPF);
	endfunction

	function automatic logic is_avg_mode(input logic [2:0] md);
		is_avg_mode = (md == `ARAC_MD_AVG) || (md == `ARAC_MD_BURST);
	endfunction

	logic [5:0] clkdiv_q;
	logic [7:0] refsel_q;
	logic [7:0] pre_lo_q;
	logic [4:0] pre_hi_q;
	logic [2:0] computation_mode_q;
	logic [2:0] result_shift_q;
	logic [7:0] sampling_window_time_q;
	logic [7:0] repeat_target_q;
	logic auto_trigger_select_q;
	logic rc_sel_q;
	logic [15:0] thr_q;
	logic [17:0] running_sum_q;
	logic accum_overflow_flag_q;
	logic [7:0] sample_counter_q;
	logic go_q;
	arac_pkg::arac_clr_state_t clr_state_q;
	logic [2:0] rc_cnt_q;
	logic rc_s1_q, rc_s2_q, rc_s3_q;
	logic cmp_s1_q, cmp_s2_q, cmp_s3_q;
	logic [5:0] div_cnt_q;

	logic wr_ctrl2, wr_start, wr_status;
	logic rc_edge, cmp_rise, trig, clear_done, acc_now;
	logic [17:0] base_sum, base_shift, new_shift;
	logic [18:0] sum_wide;
	logic [7:0] base_cnt, cnt_next;
	logic thr_hit;
	logic [12:0] pre_val;

	assign wr_ctrl2 = reg_wr && (reg_addr == `ARAC_OFF_CTRL2);
	assign wr_start = reg_wr && (reg_addr == `ARAC_OFF_START);
	assign wr_status = reg_wr && (reg_addr == `ARAC_OFF_STATUS);
	assign pre_val = {pre_hi_q, pre_lo_q};

	// Configuration registers written by software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clkdiv_q <= 6'h00;
			refsel_q <= `ARAC_RST_BYTE;
			pre_lo_q <= `ARAC_RST_BYTE;
			pre_hi_q <= 5'h00;
			computation_mode_q <= `ARAC_MD_BASIC;
			result_shift_q <= 3'h0;
			sampling_window_time_q <= `ARAC_RST_BYTE;
			repeat_target_q <= `ARAC_RST_BYTE;
			auto_trigger_select_q <= 1'b0;
			rc_sel_q <= 1'b0;
			thr_q <= `ARAC_THR_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`ARAC_OFF_CLKDIV: clkdiv_q <= reg_wdata[5:0];
				`ARAC_OFF_REFSEL: refsel_q <= reg_wdata & 8'h13;
				`ARAC_OFF_PRE_LO: pre_lo_q <= reg_wdata;
				`ARAC_OFF_PRE_HI: pre_hi_q <= reg_wdata[4:0];
				`ARAC_OFF_CTRL2: begin
					computation_mode_q <= reg_wdata[2:0];
					result_shift_q <= reg_wdata[6:4];
				end
				`ARAC_OFF_ACQ: sampling_window_time_q <= reg_wdata;
				`ARAC_OFF_RPT: repeat_target_q <= reg_wdata;
				`ARAC_OFF_TRIGSEL:
					auto_trigger_select_q <= reg_wdata[`ARAC_TRIG_CMP_BIT];
				`ARAC_OFF_START: rc_sel_q <= reg_wdata[`ARAC_START_RC_BIT];
				`ARAC_OFF_THR_LO: thr_q[7:0] <= reg_wdata;
				`ARAC_OFF_THR_HI: thr_q[15:8] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Two-flop synchronisers; third stage only feeds edge detect
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rc_s1_q <= 1'b0;
			rc_s2_q <= 1'b0;
			rc_s3_q <= 1'b0;
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
			cmp_s3_q <= 1'b0;
		end else begin
			rc_s1_q <= internal_rc_oscillator;
			rc_s2_q <= rc_s1_q;
			rc_s3_q <= rc_s2_q;
			cmp_s1_q <= cmp_out;
			cmp_s2_q <= cmp_s1_q;
			cmp_s3_q <= cmp_s2_q;
		end
	end

	assign rc_edge = rc_s2_q && !rc_s3_q;
	assign cmp_rise = cmp_s2_q && !cmp_s3_q;

	// Triggers; one conversion in flight, extra triggers dropped
	assign trig = ((wr_start && reg_wdata[`ARAC_START_GO_BIT]) ||
		(auto_trigger_select_q && cmp_rise)) && !go_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			go_q <= 1'b0;
			conv_start <= 1'b0;
		end else begin
			conv_start <= trig;
			if (trig) begin
				go_q <= 1'b1;
			end else if (conv_result.valid) begin
				go_q <= 1'b0;
			end
		end
	end

	// Clear sequencer; RC clock is slow, so count its synced edges
	assign clear_done = (clr_state_q == arac_pkg::ARAC_CLR_WAIT) &&
		(!rc_sel_q || (rc_edge &&
		rc_cnt_q == `ARAC_RC_CLEAR_CYC - 3'h1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clr_state_q <= arac_pkg::ARAC_CLR_IDLE;
			rc_cnt_q <= 3'h0;
		end else begin
			case (clr_state_q)
				arac_pkg::ARAC_CLR_IDLE: begin
					rc_cnt_q <= 3'h0;
					if (wr_ctrl2 && reg_wdata[`ARAC_CTRL2_CLR_BIT]) begin
						clr_state_q <= arac_pkg::ARAC_CLR_WAIT;
					end
				end
				arac_pkg::ARAC_CLR_WAIT: begin
					if (clear_done) begin
						clr_state_q <= arac_pkg::ARAC_CLR_IDLE;
					end else if (rc_edge) begin
						rc_cnt_q <= rc_cnt_q + 3'h1;
					end
				end
				default: clr_state_q <= arac_pkg::ARAC_CLR_IDLE;
			endcase
		end
	end

	// Datapath; a sample landing on the clear cycle survives the clear
	assign acc_now = conv_result.valid &&
		is_acc_mode(computation_mode_q);
	assign base_sum = clear_done ? 18'h00000 : running_sum_q;
	assign base_cnt = clear_done ? 8'h00 : sample_counter_q;
	assign base_shift = base_sum >> result_shift_q;
	assign new_shift = sum_wide[17:0] >> result_shift_q;
	assign cnt_next = (base_cnt == `ARAC_CNT_MAX) ? base_cnt :
		base_cnt + 8'h01;

	always_comb begin
		if (computation_mode_q == `ARAC_MD_LPF) begin
			sum_wide = {1'b0, base_sum} - {1'b0, base_shift} +
				{7'h00, conv_result.data};
		end else begin
			sum_wide = {1'b0, base_sum} + {7'h00, conv_result.data};
		end
	end

	// Running sum, right-justified whatever the result format
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			running_sum_q <= 18'h00000;
		end else if (acc_now) begin
			running_sum_q <= sum_wide[17:0];
		end else if (clear_done) begin
			running_sum_q <= 18'h00000;
		end
	end

	// Overflow flag; a set in the clear cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			accum_overflow_flag_q <= 1'b0;
		end else if (acc_now && sum_wide[18]) begin
			accum_overflow_flag_q <= 1'b1;
		end else if (clear_done) begin
			accum_overflow_flag_q <= 1'b0;
		end
	end

	// Sample counter saturates rather than wrapping past 255
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_counter_q <= 8'h00;
		end else if (acc_now) begin
			sample_counter_q <= cnt_next;
		end else if (clear_done) begin
			sample_counter_q <= 8'h00;
		end
	end

	// Filtered result follows the shifted sum in every accumulating mode
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			filtered_result <= 16'h0000;
		end else if (acc_now) begin
			filtered_result <= new_shift[15:0];
		end
	end

	// Threshold test source depends on mode
	always_comb begin
		thr_hit = 1'b0;
		if (computation_mode_q == `ARAC_MD_BASIC) begin
			thr_hit = conv_result.valid &&
				({4'h0, conv_result.data} > thr_q);
		end else if (computation_mode_q == `ARAC_MD_ACCUM) begin
			thr_hit = acc_now &&
				(sum_wide[17:0] > {2'h0, thr_q});
		end else if (is_avg_mode(computation_mode_q)) begin
			thr_hit = acc_now && (cnt_next >= repeat_target_q) &&
				(new_shift > {2'h0, thr_q});
		end else if (computation_mode_q == `ARAC_MD_LPF) begin
			thr_hit = acc_now && (new_shift > {2'h0, thr_q});
		end
	end

	// Threshold flag: write one to clear, hardware set wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			threshold_event_flag <= 1'b0;
		end else if (thr_hit) begin
			threshold_event_flag <= 1'b1;
		end else if (wr_status && reg_wdata[`ARAC_STAT_THR_BIT]) begin
			threshold_event_flag <= 1'b0;
		end
	end

	// Conversion clock: toggle every field+1 cycles; >= copes with
	// the field shrinking mid-count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_q <= 6'h00;
			conv_clk <= 1'b0;
		end else if (div_cnt_q >= clkdiv_q) begin
			div_cnt_q <= 6'h00;
			conv_clk <= !conv_clk;
		end else begin
			div_cnt_q <= div_cnt_q + 6'h01;
		end
	end

	// Analog-side settings, registered so outputs come from flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_cfg <= '0;
			precharge_cycles <= 13'h0000;
			precharge_en <= 1'b0;
			sample_cycles <= 9'h000;
		end else begin
			ref_cfg.pos_ref_select <= refsel_q[1:0];
			ref_cfg.negative_ref_select <=
				refsel_q[`ARAC_REF_NEG_BIT];
			precharge_cycles <= pre_val;
			precharge_en <= (pre_val != 13'h0000);
			if ((pre_val != 13'h0000) &&
				(sampling_window_time_q == 8'h00)) begin
				sample_cycles <= `ARAC_SAMP_DEFAULT;
			end else begin
				sample_cycles <= {1'b0, sampling_window_time_q};
			end
		end
	end

	// Read port; data stands the cycle after the strobe only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`ARAC_OFF_CLKDIV: reg_rdata <= {2'h0, clkdiv_q};
				`ARAC_OFF_REFSEL: reg_rdata <= refsel_q;
				`ARAC_OFF_PRE_LO: reg_rdata <= pre_lo_q;
				`ARAC_OFF_PRE_HI: reg_rdata <= {3'h0, pre_hi_q};
				`ARAC_OFF_CTRL2: reg_rdata <= {1'b0, result_shift_q,
					clr_state_q == arac_pkg::ARAC_CLR_WAIT,
					computation_mode_q};
				`ARAC_OFF_ACQ: reg_rdata <= sampling_window_time_q;
				`ARAC_OFF_RPT: reg_rdata <= repeat_target_q;
				`ARAC_OFF_TRIGSEL: reg_rdata <= {7'h00, auto_trigger_select_q};
				`ARAC_OFF_START: reg_rdata <= {6'h00, rc_sel_q, go_q};
				`ARAC_OFF_STATUS: reg_rdata <= {6'h00, threshold_event_flag,
					accum_overflow_flag_q};
				`ARAC_OFF_SUM_LO: reg_rdata <= running_sum_q[7:0];
				`ARAC_OFF_SUM_HI: reg_rdata <= running_sum_q[15:8];
				`ARAC_OFF_SUM_UP: reg_rdata <= {6'h00, running_sum_q[17:16]};
				`ARAC_OFF_FLT_LO: reg_rdata <= filtered_result[7:0];
				`ARAC_OFF_FLT_HI: reg_rdata <= filtered_result[15:8];
				`ARAC_OFF_CNT: reg_rdata <= sample_counter_q;
				`ARAC_OFF_THR_LO: reg_rdata <= thr_q[7:0];
				`ARAC_OFF_THR_HI: reg_rdata <= thr_q[15:8];
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_ovf_set;
		acc_now && sum_wide[18] |=> accum_overflow_flag_q;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("ovf not set");

	property p_cnt_inc;
		acc_now && !clear_done && sample_counter_q != 8'hff |=>
			sample_counter_q == $past(sample_counter_q) + 8'h01;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("count slip");

	property p_clear;
		clear_done && !conv_result.valid |=> running_sum_q == 18'h00000 &&
			sample_counter_q == 8'h00 && !accum_overflow_flag_q;
	endproperty
	a_clear: assert property (p_clear) else $error("clear incomplete");

	property p_clr_self;
		clr_state_q == arac_pkg::ARAC_CLR_WAIT && !rc_sel_q && !wr_ctrl2
			|=> clr_state_q == arac_pkg::ARAC_CLR_IDLE;
	endproperty
	a_clr_self: assert property (p_clr_self) else $error("clr stuck");

	property p_rc_clear;
		clear_done && rc_sel_q |-> rc_cnt_q == 3'h4 && rc_edge;
	endproperty
	a_rc_clear: assert property (p_rc_clear) else $error("rc clr len");

	property p_basic;
		computation_mode_q == `ARAC_MD_BASIC && !clear_done
			|=> $stable(running_sum_q);
	endproperty
	a_basic: assert property (p_basic) else $error("basic accum");

	property p_flt;
		acc_now && computation_mode_q == `ARAC_MD_ACCUM |=>
			filtered_result == 16'(running_sum_q >> $past(result_shift_q));
	endproperty
	a_flt: assert property (p_flt) else $error("flt mismatch");

	property p_avg_thr;
		is_avg_mode(computation_mode_q) && acc_now &&
			cnt_next < repeat_target_q && !threshold_event_flag
			|=> !threshold_event_flag;
	endproperty
	a_avg_thr: assert property (p_avg_thr) else $error("early thr");

	property p_div;
		div_cnt_q < clkdiv_q && $stable(clkdiv_q) |=> $stable(conv_clk);
	endproperty
	a_div: assert property (p_div) else $error("div early");

	property p_cmp_trig;
		auto_trigger_select_q && cmp_rise && !go_q |=> conv_start ##1 !conv_start;
	endproperty
	a_cmp_trig: assert property (p_cmp_trig) else $error("no trig");

	c_overflow: cover property (acc_now && sum_wide[18]);
	c_rc_clear: cover property (clear_done && rc_sel_q);
	c_avg_thr: cover property (is_avg_mode(computation_mode_q) && thr_hit);

endmodule // arac_top

// ===== verification/arac_core_model.sv
module arac_core_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic conv_start,
	input wire logic [11:0] next_data,
	input wire logic [7:0] latency,
	output arac_pkg::arac_result_t conv_result
);
	timeunit 1ns;
	timeprecision 1ns;

	logic busy_q;
	logic [7:0] wait_q;

	// Answer each start after a set delay, prompt at zero, slow when large
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
			wait_q <= 8'h00;
			conv_result <= '0;
		end else begin
			conv_result.valid <= 1'b0;
			// Data lines never hold the old value outside the valid cycle
			conv_result.data <= ~conv_result.data;
			if (conv_start) begin
				busy_q <= 1'b1;
				wait_q <= latency;
			end else if (busy_q && wait_q != 8'h00) begin
				wait_q <= wait_q - 8'h01;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				conv_result.valid <= 1'b1;
				conv_result.data <= next_data;
			end
		end
	end
endmodule // arac_core_model

// ===== verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	arac_pkg::arac_result_t conv_result;
	logic cmp_out = 1'b0;
	logic rc_clk = 1'b0;
	logic conv_start;
	logic conv_clk;
	arac_pkg::arac_ref_t ref_cfg;
	logic [12:0] precharge_cycles;
	logic precharge_en;
	logic [8:0] sample_cycles;
	logic [15:0] filtered_result;
	logic threshold_event_flag;
	logic [11:0] core_data = 12'h000;
	logic [7:0] lat = 8'h00;
	logic [7:0] start_base = 8'h00;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	int starts = 0;
	int e;
	logic [7:0] e_tab [3] = '{8'h00, 8'h03, 8'h3f};

	arac_top arac_top_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .conv_result(conv_result), .cmp_out(cmp_out),
		.internal_rc_oscillator(rc_clk), .conv_start(conv_start),
		.conv_clk(conv_clk), .ref_cfg(ref_cfg),
		.precharge_cycles(precharge_cycles), .precharge_en(precharge_en),
		.sample_cycles(sample_cycles), .filtered_result(filtered_result),
		.threshold_event_flag(threshold_event_flag));

	arac_core_model arac_core_model_inst (.clk(clk), .rst_b(rst_b),
		.conv_start(conv_start), .next_data(core_data), .latency(lat),
		.conv_result(conv_result));

	// 20 MHz system clock
	always #25 clk = ~clk;

	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard, far above the few thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Config outputs are copied from the registers one clock later
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// Start pulses seen by the core, so a dropped trigger shows
	always @(posedge clk) begin
		if (conv_start === 1'b1) starts++;
	end

	// Read data lives only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic chk(input string n, input logic [17:0] x,
		input logic [17:0] g);
		compares++;
		if (g !== x) begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic chk_reg(input string n, input logic [7:0] a,
		input logic [7:0] x);
		logic [7:0] v;
		rd(a, v);
		chk(n, {10'h0, x}, {10'h0, v});
	endtask

	// Sum is read bytewise while nothing converts
	task automatic chk_sum(input logic [17:0] x);
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		rd(8'h0a, b0);
		rd(8'h0b, b1);
		rd(8'h0c, b2);
		chk("sum", x, {b2[1:0], b1, b0});
	endtask

	task automatic wait_idle;
		logic [7:0] s;
		int n;
		s = 8'h01;
		for (n = 0; n < 60 && s[0] !== 1'b0; n++) rd(8'h08, s);
		chk("busy", 18'h0, {17'h0, s[0]});
	endtask

	task automatic convert(input logic [11:0] v);
		core_data <= v;
		wr(8'h08, start_base | 8'h01);
		wait_idle();
	endtask

	// Rising edges of the divided clock over a fixed window
	task automatic edges(input int w, output int n);
		logic last;
		n = 0;
		#1;
		last = conv_clk;
		repeat (w) begin
			@(posedge clk);
			#1;
			if (conv_clk === 1'b1 && last === 1'b0) n++;
			last = conv_clk;
		end
	endtask

	task automatic rc_edges(input int k);
		repeat (k) begin
			rc_clk <= 1'b1;
			repeat (4) @(posedge clk);
			rc_clk <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		chk_reg("clkdiv", 8'h00, 8'h00);
		chk_reg("refsel", 8'h01, 8'h00);
		chk_reg("pre_lo", 8'h02, 8'h00);
		chk_reg("pre_hi", 8'h03, 8'h00);
		chk_reg("thr_lo", 8'h10, 8'hff);
		chk_reg("unmapped", 8'h3f, 8'h00);
		// Reserved bits read back as zero
		wr(8'h00, 8'hff);
		chk_reg("clkdiv", 8'h00, 8'h3f);
		wr(8'h01, 8'hff);
		chk_reg("refsel", 8'h01, 8'h13);
		for (int i = 0; i < 4; i++) begin
			wr(8'h01, 8'h10 | 8'(i));
			settle();
			chk("pos_ref", 18'(i), {16'h0, ref_cfg.pos_ref_select});
			chk("neg_ref", 18'h1, {17'h0, ref_cfg.negative_ref_select});
		end
		wr(8'h01, 8'h00);
		settle();
		chk("neg_ref", 18'h0, {17'h0, ref_cfg.negative_ref_select});
		// Precharge and sampling window coupling
		wr(8'h05, 8'h07);
		settle();
		chk("pre_en", 18'h0, {17'h0, precharge_en});
		chk("samp", 18'h7, {9'h0, sample_cycles});
		wr(8'h05, 8'h00);
		wr(8'h02, 8'h01);
		settle();
		chk("pre_en", 18'h1, {17'h0, precharge_en});
		chk("samp", 18'h100, {9'h0, sample_cycles});
		wr(8'h03, 8'hff);
		wr(8'h02, 8'hff);
		chk_reg("pre_hi", 8'h03, 8'h1f);
		chk("pre", 18'h1fff, {5'h0, precharge_cycles});
		// Divider extremes and a middle value
		foreach (e_tab[k]) begin
			wr(8'h00, e_tab[k]);
			repeat (130) @(posedge clk);
			edges(8 * (int'(e_tab[k]) + 1), e);
			chk("clk_edges", 18'h4, 18'(e));
		end
		// Accumulate, with a second start dropped while busy
		wr(8'h04, 8'h21);
		convert(12'hfff);
		convert(12'hfff);
		lat <= 8'd30;
		core_data <= 12'hfff;
		wr(8'h08, 8'h01);
		wr(8'h08, 8'h01);
		wait_idle();
		lat <= 8'd0;
		chk_sum(18'h02ffd);
		chk("starts", 18'h3, 18'(starts));
		chk_reg("cnt", 8'h0f, 8'h03);
		chk("flt", 18'h0bff, {2'h0, filtered_result});
		wr(8'h04, 8'h29);
		chk_reg("ctrl2", 8'h04, 8'h21);
		chk_sum(18'h0);
		chk_reg("cnt", 8'h0f, 8'h00);
		// 64 full-scale samples stay in range, the 65th overflows
		repeat (64) convert(12'hfff);
		chk_reg("status", 8'h09, 8'h02);
		convert(12'hfff);
		chk_reg("status", 8'h09, 8'h03);
		chk_sum(18'h00fbf);
		chk_reg("cnt", 8'h0f, 8'h41);
		chk("thr", 18'h1, {17'h0, threshold_event_flag});
		// Clear paced by the RC clock: nothing until its fifth edge
		start_base = 8'h02;
		wr(8'h08, start_base);
		wr(8'h09, 8'h02);
		wr(8'h04, 8'h29);
		rc_edges(4);
		chk_sum(18'h00fbf);
		rc_edges(1);
		chk_sum(18'h0);
		chk_reg("status", 8'h09, 8'h00);
		chk_reg("ctrl2", 8'h04, 8'h21);
		start_base = 8'h00;
		wr(8'h08, start_base);
		// Average: compare held back until count reaches target
		wr(8'h04, 8'h12);
		wr(8'h06, 8'h02);
		wr(8'h10, 8'h10);
		wr(8'h11, 8'h00);
		convert(12'h040);
		chk("thr", 18'h0, {17'h0, threshold_event_flag});
		chk("flt", 18'h20, {2'h0, filtered_result});
		convert(12'h040);
		chk("thr", 18'h1, {17'h0, threshold_event_flag});
		chk("flt", 18'h40, {2'h0, filtered_result});
		chk_reg("cnt", 8'h0f, 8'h02);
		// Burst average holds the compare back the same way
		wr(8'h09, 8'h02);
		wr(8'h04, 8'h1b);
		convert(12'h040);
		chk("thr", 18'h0, {17'h0, threshold_event_flag});
		convert(12'h040);
		chk("thr", 18'h1, {17'h0, threshold_event_flag});
		chk("flt", 18'h40, {2'h0, filtered_result});
		// Low-pass: sum - (sum >> 1) + sample
		wr(8'h09, 8'h02);
		wr(8'h04, 8'h1c);
		convert(12'h100);
		convert(12'h100);
		chk_sum(18'h00180);
		chk("flt", 18'hc0, {2'h0, filtered_result});
		// Basic: raw result compared, nothing summed
		wr(8'h09, 8'h02);
		wr(8'h04, 8'h08);
		convert(12'h00f);
		chk("thr", 18'h0, {17'h0, threshold_event_flag});
		convert(12'h020);
		chk("thr", 18'h1, {17'h0, threshold_event_flag});
		chk_sum(18'h0);
		// Comparator rising edge starts a conversion
		wr(8'h04, 8'h29);
		wr(8'h07, 8'h01);
		core_data <= 12'h123;
		cmp_out <= 1'b1;
		repeat (6) @(posedge clk);
		cmp_out <= 1'b0;
		wait_idle();
		chk_sum(18'h00123);
		chk_reg("cnt", 8'h0f, 8'h01);
		report_and_stop();
	end

endmodule // tb_top
